// ---- mss_startup_seq.sv ----
// Purpose: Startup sequencer and phase set-up of a multiphase buck.
// Assumes: Pin inputs are asynchronous; register port is on clk_i.
// Notes:   Voltage ID code is read as a target in 6.25 mV steps.
// Contract
// - Start on enable and supply, first delay
// - Blank drive six master cycles, detect phases
// - Soft-start reference to boot, paced steps
// - Boot hold one delay, then sample ID
// - Step reference to sampled ID, both directions
// - After ramp and masking, run blanking delay
// - One shared timer for all three delays
// - Delay code bits 2:0, default 2 ms
// - Latchoff time four delay periods
// - Slew code bits 2:0, default 0.5 V/ms
// - Pull down phases two-six, detect tied high
// - Phase count from phases tied downward
// - Phase one held low during detection
// - Used phases drive, tied phases high impedance
// - Phase rate is master clock over count
// - Phases independent, overlap and full duty allowed
// - Load-line scale from two calibration codes
// - Latchoff only after blanking completes
// - Enable low or supply loss clears latch
module mss_startup_seq #(
  parameter int DELAY_UNIT_CYC_P = mss_pkg::DELAY_UNIT_CYC, // 0.5 ms
  parameter int STEP_BASE_CYC_P  = mss_pkg::STEP_BASE_CYC,  // At 0.1 V/ms
  parameter int PG_MASK_CYC_P    = mss_pkg::PG_MASK_CYC     // Masking
) (
  input  wire logic                  clk_i,            // 100 MHz clock
  input  wire logic                  nrst_i,           // Sync reset, low
  input  wire logic                  enable_i,         // Enable pin
  input  wire logic                  supply_lockout_ok_i, // Supply good
  input  wire logic [4:0]            phase_tied_i,     // Phases 2-6 > 3 V
  input  wire logic [7:0]            voltage_id_code_i, // ID pins
  input  wire logic                  ilim_i,           // Current limit
  input  wire logic [5:0]            pwm_req_i,        // Modulator demand
  input  wire mss_pkg::mss_reg_req_t reg_req_i,        // Register access
  output logic [7:0]                 reg_rdata_o,      // Read data
  output logic                       reg_ack_o,        // Access done
  output logic [5:0]                 phase_drive_o,    // Phase 1-6 level
  output logic [5:0]                 phase_oe_o,       // Phase 1-6 enable
  output logic [4:0]                 phase_pulldown_o, // Sink on 2-6
  output logic [5:0]                 phase_slot_o,     // Per-phase clock
  output logic [7:0]                 ref_dac_o,        // Reference code
  output logic                       power_good_output_o, // Power good
  output logic [2:0]                 phase_count_o,    // Phases in use
  output logic [5:0]                 loadline_scale_o, // Cal plus set
  output logic                       latched_off_o,    // Latched off
  output logic [3:0]                 seq_state_o       // State code
);
  import mss_pkg::*;
  localparam int SYNC_W = 22; // enable, supply, tied, ID, limit, demand
  // Two-stage synchroniser; only the second stage is read
  logic [SYNC_W-1:0] meta_ff, sync_ff;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= {enable_i, supply_lockout_ok_i, phase_tied_i,
                  voltage_id_code_i, ilim_i, pwm_req_i};
      sync_ff <= meta_ff;
    end
  end
  logic       s_en, s_ok, s_ilim;
  logic [4:0] s_tied;
  logic [7:0] s_vid;
  logic [5:0] s_pwm;
  assign {s_en, s_ok, s_tied, s_vid, s_ilim, s_pwm} = sync_ff;
  logic go;                                   // Start condition
  assign go = s_en & s_ok;
  // Configuration registers and registered read port
  logic [2:0] dly_ff, nxt_dly;                // Delay select
  logic [2:0] slew_ff, nxt_slew;              // Slew select
  logic [4:0] llc_ff, nxt_llc;                // Load-line calibration
  logic [4:0] lls_ff, nxt_lls;                // Load-line set
  logic [7:0] rd_ff, nxt_rd;
  logic       ack_ff, nxt_ack;
  always_comb begin
    nxt_dly  = dly_ff;   nxt_slew = slew_ff;
    nxt_llc  = llc_ff;   nxt_lls  = lls_ff;
    nxt_rd   = rd_ff;
    nxt_ack  = reg_req_i.wr | reg_req_i.rd;
    if (reg_req_i.wr) begin
      if (reg_req_i.addr == ADDR_DELAY) begin
        nxt_dly = reg_req_i.wdata[SEL_W-1:0];
      end else if (reg_req_i.addr == ADDR_SLEW) begin
        nxt_slew = reg_req_i.wdata[SEL_W-1:0];
      end else if (reg_req_i.addr == ADDR_LL_CAL) begin
        nxt_llc = reg_req_i.wdata[LL_W-1:0];
      end else if (reg_req_i.addr == ADDR_LL_SET) begin
        nxt_lls = reg_req_i.wdata[LL_W-1:0];
      end
    end
    if (reg_req_i.rd) begin
      // Upper bits read as zero; unmapped codes read zero
      if (reg_req_i.addr == ADDR_DELAY) begin
        nxt_rd = {5'h0, dly_ff};
      end else if (reg_req_i.addr == ADDR_SLEW) begin
        nxt_rd = {5'h0, slew_ff};
      end else if (reg_req_i.addr == ADDR_LL_CAL) begin
        nxt_rd = {3'h0, llc_ff};
      end else if (reg_req_i.addr == ADDR_LL_SET) begin
        nxt_rd = {3'h0, lls_ff};
      end else begin
        nxt_rd = 8'h00;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      dly_ff  <= DELAY_RST;
      slew_ff <= SLEW_RST;
      llc_ff  <= LL_RST;   lls_ff  <= LL_RST;
      rd_ff   <= 8'h00;    ack_ff  <= 1'b0;
    end else begin
      dly_ff  <= nxt_dly;  slew_ff <= nxt_slew;
      llc_ff  <= nxt_llc;  lls_ff  <= nxt_lls;
      rd_ff   <= nxt_rd;   ack_ff  <= nxt_ack;
    end
  end
  // Step period per slew code: base over 1, 3, 5 ... 15
  logic [SCNT_W-1:0] step_tab [8];
  for (genvar g = 0; g < 8; g++) begin : g_step
    assign step_tab[g] = SCNT_W'(STEP_BASE_CYC_P / (2 * g + 1));
  end
  logic [SCNT_W-1:0] step_lim;
  assign step_lim = step_tab[slew_ff];
  // Master clock enable; the oscillator rate is a divide of clk_i
  logic [MDIV_W-1:0] mdiv_ff, nxt_mdiv;
  logic              mtick;
  assign mtick = (mdiv_ff == MDIV_W'(MCLK_DIV - 1));
  always_comb nxt_mdiv = mtick ? '0 : mdiv_ff + 8'h1;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) mdiv_ff <= '0;
    else         mdiv_ff <= nxt_mdiv;
  end
  // Shared delay timer
  logic t_start, t_cancel, t_mult4, t_busy, t_done;
  mss_delay_timer #(.UNIT_CYC(DELAY_UNIT_CYC_P)) u_timer (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .start_i  (t_start),
    .cancel_i (t_cancel),
    .mult4_i  (t_mult4),
    .code_i   (dly_ff),
    .busy_o   (t_busy),
    .done_o   (t_done)
  );
  // Phases in use: a phase counts only if it and all below are untied
  logic [5:0] det_used;
  logic [2:0] det_cnt;
  assign det_used[0] = 1'b1;
  for (genvar p = 1; p < NPH; p++) begin : g_used
    assign det_used[p] = det_used[p-1] & ~s_tied[p-1];
  end
  always_comb begin
    det_cnt = 3'h0;
    for (int k = 0; k < NPH; k++) det_cnt = det_cnt + 3'(det_used[k]);
  end
  // Sequencer state
  mss_state_t        st_ff, nxt_st;
  logic [7:0]        dac_ff, nxt_dac;        // Reference code
  logic [7:0]        vid_ff, nxt_vid;        // Sampled target
  logic [SCNT_W-1:0] scnt_ff, nxt_scnt;      // Step or mask count
  logic [2:0]        dcnt_ff, nxt_dcnt;      // Detection cycles
  logic [5:0]        used_ff, nxt_used;      // Phases in use
  logic [2:0]        nph_ff, nxt_nph;        // Phase count
  logic              pg_ff, nxt_pg;
  logic              ocr_ff, nxt_ocr;        // Latchoff timing
  logic              step_due;
  assign step_due = (scnt_ff >= step_lim - 16'h1);
  // Sequence: abort has top priority, then the per-state progress
  always_comb begin
    nxt_st = st_ff;  nxt_dac = dac_ff;  nxt_vid = vid_ff;
    nxt_scnt = scnt_ff;  nxt_dcnt = dcnt_ff;  nxt_used = used_ff;
    nxt_nph = nph_ff;  nxt_pg = pg_ff;  nxt_ocr = ocr_ff;
    t_start = 1'b0;  t_cancel = 1'b0;  t_mult4 = 1'b0;
    if (!go && st_ff != MSS_IDLE) begin
      nxt_st = MSS_IDLE;
      t_cancel = 1'b1;
      nxt_dac = 8'h00;  nxt_pg = 1'b0;  nxt_ocr = 1'b0;
    end else begin
      case (st_ff)
        MSS_IDLE: if (go) begin
          nxt_st = MSS_INIT;
          t_start = 1'b1;
          nxt_dac = 8'h00;
        end
        MSS_INIT: if (t_done) begin
          nxt_st = MSS_DETECT;
          nxt_dcnt = 3'h0;
        end
        MSS_DETECT: if (mtick) begin
          nxt_dcnt = dcnt_ff + 3'h1;
          if (dcnt_ff == 3'(DETECT_MCLK - 1)) begin
            nxt_used = det_used;
            nxt_nph = det_cnt;
            nxt_st = MSS_SOFT;
            nxt_scnt = '0;
          end
        end
        MSS_SOFT: begin
          nxt_scnt = step_due ? '0 : scnt_ff + 16'h1;
          if (step_due) begin
            nxt_dac = dac_ff + 8'h1;
            if (dac_ff + 8'h1 == BOOT_LVL) begin
              nxt_st = MSS_BOOT;
              t_start = 1'b1;
            end
          end
        end
        MSS_BOOT: if (t_done) begin
          nxt_vid = s_vid;
          nxt_st = MSS_FINAL;
          nxt_scnt = '0;
        end
        MSS_FINAL: if (dac_ff == vid_ff) begin
          nxt_st = MSS_MASK;
          nxt_scnt = '0;
        end else begin
          nxt_scnt = step_due ? '0 : scnt_ff + 16'h1;
          if (step_due) begin
            nxt_dac = (vid_ff > dac_ff) ? dac_ff + 8'h1 : dac_ff - 8'h1;
          end
        end
        MSS_MASK: if (scnt_ff == SCNT_W'(PG_MASK_CYC_P - 1)) begin
          nxt_st = MSS_BLANK;
          t_start = 1'b1;
        end else begin
          nxt_scnt = scnt_ff + 16'h1;
        end
        MSS_BLANK: if (t_done) begin
          nxt_st = MSS_RUN;
          nxt_pg = 1'b1;
        end
        MSS_RUN: begin
          // Limit is only watched here, so startup always completes
          if (ocr_ff && t_done) begin
            nxt_st = MSS_LATCH;
            nxt_pg = 1'b0;
            nxt_ocr = 1'b0;
          end else if (s_ilim && !ocr_ff) begin
            t_start = 1'b1;
            t_mult4 = 1'b1;
            nxt_ocr = 1'b1;
          end else if (!s_ilim && ocr_ff) begin
            t_cancel = 1'b1;                               // Recovered
            nxt_ocr = 1'b0;
          end
        end
        MSS_LATCH: nxt_st = MSS_LATCH;
        default: nxt_st = MSS_IDLE;
      endcase
    end
  end
  // Pin and clock outputs, all registered
  logic [5:0] drv_ff, nxt_drv, oe_ff, nxt_oe, slot_ff, nxt_slot;
  logic [4:0] pd_ff, nxt_pd;
  logic       active, detecting, lat_ff;
  assign active = (nxt_st inside {MSS_SOFT, MSS_BOOT, MSS_FINAL,
                                  MSS_MASK, MSS_BLANK, MSS_RUN});
  assign detecting = go && (nxt_st inside {MSS_IDLE, MSS_INIT, MSS_DETECT});
  always_comb begin
    // Each phase follows its own demand; overlap is allowed
    nxt_drv = active ? (s_pwm & nxt_used) : 6'h00;
    // Phase one always driven, low while blanked
    nxt_oe = {active ? nxt_used[5:1] : 5'h00, 1'b1};
    nxt_pd = detecting ? 5'h1f : 5'h00;
    nxt_slot = slot_ff;
    if (!active) begin
      nxt_slot = 6'h01;
    end else if (mtick) begin
      // Rotate over the phases in use only
      nxt_slot = slot_ff[nph_ff - 3'h1] ? 6'h01 : {slot_ff[4:0], 1'b0};
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_ff <= MSS_IDLE;  dac_ff <= 8'h00;  vid_ff <= 8'h00;
      scnt_ff <= '0;  dcnt_ff <= 3'h0;  used_ff <= 6'h01;
      nph_ff <= 3'h1;  pg_ff <= 1'b0;  ocr_ff <= 1'b0;
      drv_ff <= 6'h00;  oe_ff <= 6'h01;  pd_ff <= 5'h00;
      slot_ff <= 6'h01;  lat_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;  dac_ff <= nxt_dac;  vid_ff <= nxt_vid;
      scnt_ff <= nxt_scnt;  dcnt_ff <= nxt_dcnt;  used_ff <= nxt_used;
      nph_ff <= nxt_nph;  pg_ff <= nxt_pg;  ocr_ff <= nxt_ocr;
      drv_ff <= nxt_drv;  oe_ff <= nxt_oe;  pd_ff <= nxt_pd;
      slot_ff <= nxt_slot;  lat_ff <= (nxt_st == MSS_LATCH);
    end
  end
  logic [5:0] ll_ff;                          // Load-line scale
  always_ff @(posedge clk_i) begin
    if (!nrst_i) ll_ff <= 6'h20;
    else         ll_ff <= {1'b0, llc_ff} + {1'b0, lls_ff};
  end
  assign reg_rdata_o = rd_ff;  assign reg_ack_o = ack_ff;
  assign phase_drive_o = drv_ff;  assign phase_oe_o = oe_ff;
  assign phase_pulldown_o = pd_ff;  assign phase_slot_o = slot_ff;
  assign ref_dac_o = dac_ff;  assign power_good_output_o = pg_ff;
  assign phase_count_o = nph_ff;  assign loadline_scale_o = ll_ff;
  assign latched_off_o = lat_ff;
  assign seq_state_o = st_ff;
  // Checks: timer length is guarded inside the timer itself
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_IDLE_HOLD: assert property ((st_ff == MSS_IDLE && !go) |=>
    st_ff == MSS_IDLE) else $error("Started without enable");
  AST_FIRST_DELAY: assert property ((st_ff == MSS_IDLE && go) |=>
    (st_ff == MSS_INIT && t_busy)) else $error("No initial delay");
  AST_DETECT_BLANK: assert property (st_ff == MSS_DETECT |->
    (drv_ff == 6'h00 && oe_ff[0])) else $error("Drive during detect");
  AST_SOFT_STEP: assert property ((st_ff == MSS_SOFT && go) |=>
    (dac_ff == $past(dac_ff) || dac_ff == $past(dac_ff) + 8'h1))
    else $error("Soft-start step wrong");
  AST_BOOT_LEVEL: assert property ((st_ff == MSS_BOOT) |->
    dac_ff == BOOT_LVL) else $error("Boot hold off level");
  AST_FINAL_DIR: assert property ((st_ff == MSS_FINAL && go &&
    dac_ff != vid_ff && $changed(dac_ff)) |->
    ((vid_ff > $past(dac_ff)) ? dac_ff == $past(dac_ff) + 8'h1
                              : dac_ff == $past(dac_ff) - 8'h1))
    else $error("Final ramp direction wrong");
  AST_PG_RISE: assert property ($rose(pg_ff) |->
    $past(st_ff) == MSS_BLANK) else $error("Power good early");
  AST_LATCH_RUN: assert property ((st_ff == MSS_LATCH &&
    $past(st_ff) != MSS_LATCH) |-> $past(st_ff) == MSS_RUN)
    else $error("Latchoff outside run");
  AST_ABORT: assert property ((!go && st_ff != MSS_IDLE) |=>
    (st_ff == MSS_IDLE && !pg_ff)) else $error("Abort missed");
  AST_HIZ: assert property (st_ff == MSS_RUN |->
    (oe_ff[5:1] == used_ff[5:1] && pd_ff == 5'h00))
    else $error("Tied phase driven");
  COV_RUN: cover property (st_ff == MSS_BLANK ##1 st_ff == MSS_RUN);
  COV_LATCH: cover property (st_ff == MSS_RUN ##1 st_ff == MSS_LATCH);
  COV_DOWN: cover property (st_ff == MSS_FINAL && vid_ff < dac_ff);
  COV_ONE_PHASE: cover property (st_ff == MSS_SOFT && nph_ff == 3'h1);
endmodule

// ---- mss_pkg.sv ----
// Purpose: Shared constants and types of the multiphase startup sequencer.
// Assumes: 100 MHz system clock, 8-bit command codes and data.
// Notes:   Reference code counts 6.25 mV steps from zero volts.
package mss_pkg;
  // Clock
  localparam int CLK_PERIOD_NS = 10;          // System clock period
  // Command codes of the configuration registers
  localparam logic [7:0] ADDR_DELAY  = 8'hd4; // Startup delay select
  localparam logic [7:0] ADDR_SLEW   = 8'hd5; // Soft-start slew select
  localparam logic [7:0] ADDR_LL_CAL = 8'hde; // Load-line calibration
  localparam logic [7:0] ADDR_LL_SET = 8'hdf; // Load-line set
  // Field layout and reset values
  localparam int SEL_W = 3;                   // Select field, bits 2:0
  localparam int LL_W  = 5;                   // Load-line field, bits 4:0
  localparam logic [2:0] DELAY_RST = 3'h3;    // 2 ms
  localparam logic [2:0] SLEW_RST  = 3'h2;    // 0.5 V/ms
  localparam logic [4:0] LL_RST    = 5'h10;   // Mid scale
  // Delay timer: 0.5 ms per code step plus one
  localparam int DELAY_UNIT_US  = 500;
  localparam int DELAY_UNIT_CYC = DELAY_UNIT_US * 1000 / CLK_PERIOD_NS;
  localparam int OC_MULT        = 4;          // Latchoff = 4 delay periods
  localparam int TCNT_W         = 20;         // Timer sub-count width
  localparam int TLEFT_W        = 5;          // Timer unit-count width
  // Reference stepping: 6.25 mV per step, slew 0.1 V/ms per unit
  localparam int STEP_UV        = 6250;
  localparam int SLEW_UNIT_UV_US = 100;
  localparam int STEP_BASE_CYC  =
    STEP_UV * 1000 / (SLEW_UNIT_UV_US * CLK_PERIOD_NS);
  localparam int BOOT_UV        = 1100000;    // 1.1 V boot level
  localparam logic [7:0] BOOT_LVL = 8'(BOOT_UV / STEP_UV);
  // Power-good masking after the final ramp
  localparam int PG_MASK_US     = 100;
  localparam int PG_MASK_CYC    = PG_MASK_US * 1000 / CLK_PERIOD_NS;
  localparam int SCNT_W         = 16;         // Step and mask counter
  // Phases
  localparam int NPH            = 6;          // Phase outputs
  localparam int DETECT_MCLK    = 6;          // Detection master cycles
  localparam int MCLK_DIV       = 10;         // Master clock divide ratio
  localparam int MDIV_W         = 8;

  typedef enum logic [3:0] {
    MSS_IDLE   = 4'h0,  // Waiting for enable and supply
    MSS_INIT   = 4'h1,  // initial_delay_phase
    MSS_DETECT = 4'h2,  // Phase detection, drive blanked
    MSS_SOFT   = 4'h3,  // first_softstart_phase
    MSS_BOOT   = 4'h4,  // boot_hold_phase
    MSS_FINAL  = 4'h5,  // final_ramp_phase
    MSS_MASK   = 4'h6,  // Power-good masking
    MSS_BLANK  = 4'h7,  // power_good_blank_phase
    MSS_RUN    = 4'h8,  // Regulating
    MSS_LATCH  = 4'h9   // Overcurrent latched off
  } mss_state_t;

  typedef struct packed {
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
    logic [7:0] addr;   // Command code
    logic [7:0] wdata;  // Write data
  } mss_reg_req_t;
endpackage

// ---- mss_delay_timer.sv ----
// Purpose: Shared delay timer for the startup delays and latchoff.
// Assumes: start and cancel come from logic on the same clock.
// Notes:   Period is (code+1) units, or four times that when mult4_i.
module mss_delay_timer #(
  parameter int UNIT_CYC = mss_pkg::DELAY_UNIT_CYC  // Cycles per 0.5 ms
) (
  input  wire logic                     clk_i,    // System clock
  input  wire logic                     nrst_i,   // Sync reset, low
  input  wire logic                     start_i,  // Load and run
  input  wire logic                     cancel_i, // Stop, no done
  input  wire logic                     mult4_i,  // Latchoff length
  input  wire logic [mss_pkg::SEL_W-1:0] code_i,  // Delay select
  output logic                          busy_o,   // Running
  output logic                          done_o    // End pulse
);
  import mss_pkg::*;

  logic [TCNT_W-1:0]  sub_ff, nxt_sub;     // Cycles left in this unit
  logic [TLEFT_W-1:0] left_ff, nxt_left;   // Whole units still to run
  logic               busy_ff, nxt_busy;   // Running flag
  logic               done_ff, nxt_done;   // End pulse

  // Two-level count keeps the counter narrow for the 4x latchoff span
  always_comb begin
    nxt_sub  = sub_ff;
    nxt_left = left_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (cancel_i) begin
      nxt_busy = 1'b0;
    end else if (start_i) begin
      nxt_busy = 1'b1;
      nxt_sub  = TCNT_W'(UNIT_CYC - 1);
      // Units minus one: code, or code*4+3 for the latchoff span
      nxt_left = mult4_i ? {code_i, 2'b11} : {2'h0, code_i};
    end else if (busy_ff) begin
      if (sub_ff == '0) begin
        if (left_ff == '0) begin
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
        end else begin
          nxt_left = left_ff - 5'h1;
          nxt_sub  = TCNT_W'(UNIT_CYC - 1);
        end
      end else begin
        nxt_sub = sub_ff - 20'h1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sub_ff  <= '0;
      left_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      sub_ff  <= nxt_sub;
      left_ff <= nxt_left;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign busy_o = busy_ff;
  assign done_o = done_ff;

  // Checks: a helper count from each start, held against the code
  int hcnt_ff;                              // Cycles since start
  int hexp_ff;                              // Expected span in cycles
  always_ff @(posedge clk_i) begin
    if (start_i) begin
      hcnt_ff <= 1;
      hexp_ff <= (int'(code_i) + 1) * UNIT_CYC * (mult4_i ? OC_MULT : 1);
    end else begin
      hcnt_ff <= hcnt_ff + 1;
    end
  end
  AST_TIMER_LEN: assert property (@(posedge clk_i)
    disable iff (!nrst_i) done_ff |-> hcnt_ff == hexp_ff + 1)
    else $error("Delay length wrong");
endmodule

// ---- mss_board_model.sv ----
// Purpose: Board strapping and gate driver inputs on the phase pins.
// Assumes: Unused phases are strapped to the supply from phase six down.
// Notes:   Driver inputs have a weak sink, so an undriven pin reads low.
module mss_board_model #(
  parameter int N_TIED = 2                  // Phases strapped high
) (
  input  wire logic [5:0] drive_i,          // Device drive level
  input  wire logic [5:0] oe_i,             // Device output enable
  output logic      [4:0] tied_o            // Comparator, phases 2-6
);
  logic [5:0] strap;                        // Pins tied to the supply
  logic [5:0] pin;                          // Resolved pin level
  // Strap from the top phase downward, never a gap in between
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      strap[i] = (i >= 6 - N_TIED);
      // Supply tie wins; a driven pin follows; else the sink holds it low
      pin[i] = strap[i] | (oe_i[i] & drive_i[i]);
    end
    tied_o = pin[5:1];                      // Above 3 V threshold
  end
endmodule

// ---- tb_mss_startup_seq.sv ----
// Purpose: Self-checking bench of the startup sequencer.
// Assumes: Two phases strapped high, shortened timer units.
// Notes:   Timer lengths are compared per state; the initial delay is also checked against DU + 1.
module tb_mss_startup_seq;
  timeunit 1ns;
  timeprecision 100ps;
  import mss_pkg::*;
  localparam int DU = 20;                   // Cycles per delay unit
  logic clk_i = 0, nrst_i = 0, en = 0, sup = 0, ilim = 0;
  logic [7:0] voltage_id_code = 8'hb8;                  // Target above boot level
  logic [5:0] pwm = 6'h35;                  // Demand on phases 1, 3, 5, 6
  mss_reg_req_t req = '0;
  logic [7:0] rdata, dac;
  logic [5:0] drv, oe, slot, lls;
  logic [4:0] tied, pd;
  logic [3:0] st;
  logic [2:0] npc;
  logic ack, pg, lat;
  int errors = 0, n_checks = 0, cnt[16];
  always #5 clk_i = ~clk_i;
  mss_startup_seq #(.DELAY_UNIT_CYC_P(DU), .STEP_BASE_CYC_P(30),
    .PG_MASK_CYC_P(10)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .enable_i(en), .supply_lockout_ok_i(sup), .phase_tied_i(tied),
    .voltage_id_code_i(voltage_id_code), .ilim_i(ilim), .pwm_req_i(pwm),
    .reg_req_i(req), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .phase_drive_o(drv), .phase_oe_o(oe), .phase_pulldown_o(pd),
    .phase_slot_o(slot), .ref_dac_o(dac), .power_good_output_o(pg),
    .phase_count_o(npc), .loadline_scale_o(lls), .latched_off_o(lat),
    .seq_state_o(st));
  mss_board_model #(.N_TIED(2)) i_board (.drive_i(drv), .oe_i(oe),
    .tied_o(tied));
  // Cycles spent in each state, for comparing timer lengths
  always @(posedge clk_i) if (nrst_i) cnt[st] <= cnt[st] + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle strobe; ack and data land one edge after it is taken
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_i);
    check(ack, 1);
    q = rdata;
    req = '0;
  endtask
  // Bounded wait for a state code
  task automatic wait_st(input logic [3:0] s);
    int n;
    n = 0;
    while (st !== s && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    check(st, s);
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    errors++;
    results();
  end
  initial begin
    logic [7:0] q;
    repeat (12) @(negedge clk_i);
    nrst_i = 1;
    access(0, ADDR_DELAY, 0, q); check(q, 8'h03);
    access(0, ADDR_SLEW, 0, q); check(q, 8'h02);
    access(0, 8'h42, 0, q); check(q, 8'h00);
    check(lls, 6'h20);
    access(1, ADDR_DELAY, 8'hf8, q);
    access(0, ADDR_DELAY, 0, q); check(q, 8'h00);
    $display("test registers done");
    en = 1;
    repeat (20) @(negedge clk_i);
    check(st, 4'h0);
    sup = 1;
    wait_st(4'h2);
    check({pd, oe, drv}, {5'h1f, 6'h01, 6'h00});
    wait_st(4'h3);
    repeat (4) @(negedge clk_i);
    check(cnt[2] > 5 * MCLK_DIV && cnt[2] <= 6 * MCLK_DIV, 1);
    check({npc, oe, pd}, {3'd4, 6'h0f, 5'h00});
    check(drv, 6'h05);
    wait_st(4'h4);
    check(dac, BOOT_LVL);
    wait_st(4'h8);
    check(dac, voltage_id_code);
    check(pg, 1);
    check(cnt[4], cnt[1]);
    check(cnt[7], cnt[1]);
    check(cnt[1], DU + 1);
    check(cnt[6], 10);
    q = {2'h0, slot};
    repeat (MCLK_DIV) @(negedge clk_i);
    check(slot != q[5:0], 1);
    repeat (3 * MCLK_DIV) @(negedge clk_i);
    check(slot, q);
    check(slot & 6'h30, 6'h00);
    $display("test startup done");
    ilim = 1;
    repeat (4 * DU - 8) @(negedge clk_i);
    check({st, lat}, {4'h8, 1'b0});
    repeat (16) @(negedge clk_i);
    check({st, lat, pg}, {4'h9, 2'b10});
    en = 0;
    ilim = 0;
    repeat (4) @(negedge clk_i);
    check({st, lat, pg, dac}, 15'h0);
    $display("test latchoff done");
    results();
  end
endmodule
